/* File: sine_pattern_generator.sv */
`timescale 1ns/10ps
module sine_pattern_generator
(
	input  wire logic                    sys_clk,
	input  wire logic                    nrst,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    demod_status,
	output sine_gen_pkg::dac_drive_s     dac_drive,
	output logic [7:0]                   demod_amp_control
);

	logic [7:0]  sine_control_q;
	logic [7:0]  clock_divider_factor_q;
	logic [5:0]  samples_per_cycle_count_q;
	logic [7:0]  demod_q;
	logic [7:0]  ram_q [sine_gen_pkg::ram_bytes];
	logic [7:0]  div_cnt_q;
	logic [5:0]  sample_idx_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        gen_enable;
	logic        gen_restart;
	logic        gen_hold;
	logic        wr_go;
	logic        wr_ram;
	logic        rd_ram;
	logic [6:0]  wr_ram_idx;
	logic [6:0]  rd_ram_idx;
	logic [6:0]  lo_idx;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        wr_ok;

	assign gen_enable  = sine_control_q[sine_gen_pkg::enable_bit];
	assign gen_restart = sine_control_q[sine_gen_pkg::restart_bit];
	// Restart is a level: the generator stays parked while the bit is high and runs from sample 0 once it drops.
	assign gen_hold    = !gen_enable || gen_restart; // [RULE9] [RULE13]

	// Write channel: address and data are captured separately in either order.
	assign wr_go      = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_ram     = awaddr_q[7] && !gen_enable; // [RULE6]
	assign wr_ram_idx = awaddr_q[6:0] >> 2;
	assign rd_ram     = s_axi_araddr[7] && !gen_enable; // [RULE6]
	assign rd_ram_idx = s_axi_araddr[6:0] >> 2;
	// The RAM window answers only while the generator is stopped; the CPU never sees a half-fetched sample.
	assign wr_ok      = (awaddr_q[7] && !gen_enable) || awaddr_q == sine_gen_pkg::ctrl_off
		|| awaddr_q == sine_gen_pkg::divider_off || awaddr_q == sine_gen_pkg::count_off
		|| awaddr_q == sine_gen_pkg::demod_off; // [RULE6]

	// Write address channel: the address is parked until the data half has also arrived.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			aw_held_q     <= 1'b0;
			awaddr_q      <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
			if (wr_go)
				aw_held_q <= 1'b0;
			else if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
		end
	end

	// Write data channel: data may come before, with or after its address.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			w_held_q     <= 1'b0;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
			if (wr_go)
				w_held_q <= 1'b0;
			else if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
		end
	end

	// Write response: one answer per write, held until the master takes it.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sine_gen_pkg::resp_okay;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? sine_gen_pkg::resp_okay : sine_gen_pkg::resp_slverr; // [RULE6]
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			sine_control_q <= sine_gen_pkg::ctrl_reset;
		else if (wr_go && wstrb_q[0] && awaddr_q == sine_gen_pkg::ctrl_off)
			sine_control_q <= wdata_q[7:0] & 8'h81; // [RULE11]
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			clock_divider_factor_q <= sine_gen_pkg::divider_reset;
		else if (wr_go && wstrb_q[0] && awaddr_q == sine_gen_pkg::divider_off)
			clock_divider_factor_q <= wdata_q[7:0]; // [RULE10]
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			samples_per_cycle_count_q <= sine_gen_pkg::count_reset;
		else if (wr_go && wstrb_q[0] && awaddr_q == sine_gen_pkg::count_off)
			samples_per_cycle_count_q <= wdata_q[5:0]; // [RULE12]
	end

	// Status bit 5 is never stored; it is read live from the comparator input.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			demod_q <= sine_gen_pkg::demod_reset;
		else if (wr_go && wstrb_q[0] && awaddr_q == sine_gen_pkg::demod_off)
			demod_q <= wdata_q[7:0] & sine_gen_pkg::demod_rw_mask;
	end

	// Pattern RAM: one byte per word; even byte holds sample bits 7..0, odd byte bits 9..8.
	always_ff @(posedge sys_clk)
	begin
		if (wr_go && wr_ram && wstrb_q[0]) // [RULE5] [RULE6]
			ram_q[wr_ram_idx] <= (wr_ram_idx[0]) ? {6'h00, wdata_q[1:0]} : wdata_q[7:0];
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (rd_ram)
			rd_word = {24'h000000, ram_q[rd_ram_idx]};
		else
		begin
			unique case (s_axi_araddr)
				sine_gen_pkg::ctrl_off:
					rd_word = {24'h000000, sine_control_q & 8'h81}; // [RULE11]
				sine_gen_pkg::divider_off:
					rd_word = {24'h000000, clock_divider_factor_q};
				sine_gen_pkg::count_off:
					rd_word = {26'h0000000, samples_per_cycle_count_q};
				sine_gen_pkg::demod_off:
					rd_word = {24'h000000, demod_q[7:6], demod_status, 1'b0, demod_q[3:0]};
				default:
					rd_ok = 1'b0; // [RULE6]
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= sine_gen_pkg::resp_okay;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? sine_gen_pkg::resp_okay : sine_gen_pkg::resp_slverr;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Divider: one sample step every N = factor + 1 clocks, so a full cycle takes N * DN clocks.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst || gen_hold)
			div_cnt_q <= 8'h00;
		else if (div_cnt_q == clock_divider_factor_q) // [RULE10] [RULE1]
			div_cnt_q <= 8'h00;
		else
			div_cnt_q <= div_cnt_q + 8'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst || gen_hold)
			sample_idx_q <= 6'h00; // [RULE13] [RULE9]
		else if (div_cnt_q == clock_divider_factor_q) // [RULE2]
		begin
			if (sample_idx_q == samples_per_cycle_count_q) // [RULE12] [RULE13]
				sample_idx_q <= 6'h00;
			else
				sample_idx_q <= sample_idx_q + 6'h01; // [RULE7]
		end
	end

	assign lo_idx = {sample_idx_q, 1'b0};

	// Output is registered, so the converter sees each sample one clock after the counter moves.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			dac_drive         <= '0;
			demod_amp_control <= sine_gen_pkg::demod_reset;
		end
		else
		begin
			dac_drive.powered <= gen_enable; // [RULE8]
			dac_drive.restart <= gen_restart; // [RULE9]
			demod_amp_control <= demod_q;
			if (gen_enable)
				dac_drive.sample <= {ram_q[lo_idx + 7'h01][1:0], ram_q[lo_idx]}; // [RULE5] [RULE7]
			else
				dac_drive.sample <= 10'h000; // [RULE8]
		end
	end

endmodule

/* File: sine_gen_pkg.sv */
// Behaviour
// RULE1 - Sine frequency equals system clock divided by M, where M is N times samples per cycle.
// RULE2 - Clock divider feeds a 6-bit sample counter stepping at clock times DN over M.
// RULE3 - Software picks settings so M is a multiple of N and of 8.
// RULE4 - Software keeps samples per cycle at no more than 64.
// RULE5 - Each sample is a byte pair: low byte even address, top two bits odd.
// RULE6 - While enabled, processor access to pattern RAM is blocked; generator owns it.
// RULE7 - Generator walks the whole pattern first to last, feeding the converter, repeating forever.
// RULE8 - Enable bit 7 starts generator; when 0 amplifier and converter stay powered down. Code powers down the converter only.
// RULE9 - Restart bit 0 pulsed high then low resets generator; output resumes from first sample.
// RULE10 - Divider factor N is the 8-bit divider register value plus one.
// RULE11 - Control register bits 6 to 1 read as zero.
// RULE12 - Samples per cycle is the 6-bit count field plus one; IQ mode needs multiple of 8.
// RULE13 - Sample counter wraps to zero and is held at zero while disabled or restarting.
package sine_gen_pkg;

	localparam logic [7:0] ctrl_off       = 8'h00;
	localparam logic [7:0] divider_off    = 8'h04;
	localparam logic [7:0] count_off      = 8'h08;
	localparam logic [7:0] demod_off      = 8'h0c;
	localparam logic [7:0] ram_base_off   = 8'h80;
	localparam int         enable_bit     = 7;
	localparam int         restart_bit    = 0;
	localparam int         ram_bytes      = 128;
	localparam logic [7:0] ctrl_reset     = 8'h00;
	localparam logic [7:0] divider_reset  = 8'h00;
	localparam logic [5:0] count_reset    = 6'h00;
	localparam logic [7:0] demod_reset    = 8'h00;
	localparam logic [7:0] demod_rw_mask  = 8'hcf;
	localparam logic [1:0] resp_okay      = 2'b00;
	localparam logic [1:0] resp_slverr    = 2'b10;

	typedef struct packed {
		logic       powered;
		logic       restart;
		logic [9:0] sample;
	} dac_drive_s;

endpackage

/* File: dac_model.sv */
`timescale 1ns/10ps
module dac_model
(
	input  wire logic                     sys_clk,
	input  wire sine_gen_pkg::dac_drive_s dac_drive,
	output logic [9:0]                    level
);
	// A converter in power down gives no output, so the level falls to zero instead of keeping the last code.
	always_ff @(posedge sys_clk)
	begin
		level <= dac_drive.powered ? dac_drive.sample : 10'h000;
	end
endmodule

/* File: sine_gen_sva.sv */
`timescale 1ns/10ps
module sine_gen_sva
(
	input wire logic                     sys_clk,
	input wire logic                     nrst,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	input wire sine_gen_pkg::dac_drive_s dac_drive
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	AST_OFF: assert property (!dac_drive.powered [*2] |-> dac_drive.sample == 10'h000)
		else $error("sample while off");
	AST_RESTART: assert property ((dac_drive.restart && dac_drive.powered) [*4] |-> $stable(dac_drive.sample))
		else $error("sample moved in restart");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready too long");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("no write answer");
endmodule

bind sine_pattern_generator sine_gen_sva i_sva (.*);

/* File: sine_pattern_generator_tb_top.sv */
`timescale 1ns/10ps
module sine_pattern_generator_tb_top;
	logic                     sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, demod_status;
	logic [7:0]               s_axi_awaddr, s_axi_araddr, demod_amp_control;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic [9:0]               level;
	sine_gen_pkg::dac_drive_s dac_drive;
	int                       mismatches, checks_done, k;

	sine_pattern_generator i_dut (.*);
	dac_model i_dac (.*);

	always #4 sys_clk = ~sys_clk;

	function automatic logic [9:0] smp(input int i);
		return 10'h0c3 + 10'(i) * 10'h0a7;
	endfunction

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Ready is raised with the request so that the answer is taken at the first edge where it stands.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do
		begin
			@(posedge sys_clk);
			s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
			s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
		end
		while (!(w ? s_axi_bvalid : s_axi_rvalid));
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		chk(w ? {s_axi_bresp, d} : {s_axi_rresp, s_axi_rdata}, {er, d});
	endtask

	task automatic final_report();
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#40000;
		mismatches++;
		$display("FAIL %0t watchdog", $time);
		final_report();
	end

	initial
	begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		demod_status = 1'b1;
		mismatches = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(0, 8'h00, 32'h00, 2'b00);
		bus(0, 8'h04, 32'h00, 2'b00);
		bus(1, 8'h00, 32'h7f, 2'b00);
		bus(0, 8'h00, 32'h01, 2'b00);
		bus(1, 8'h0c, 32'hff, 2'b00);
		bus(0, 8'h0c, 32'hef, 2'b00);
		chk(34'(demod_amp_control), 34'hcf);
		demod_status <= 1'b0;
		bus(0, 8'h0c, 32'hcf, 2'b00);
		bus(0, 8'h10, 32'h00, 2'b10);
		bus(1, 8'h04, 32'h02, 2'b00);
		bus(1, 8'h08, 32'h07, 2'b00);
		for (k = 0; k < 16; k++)
			bus(1, 8'h80 + 8'(4 * k), 32'(smp(k / 2) >> (8 * (k % 2))) & 32'hff, 2'b00);
		bus(0, 8'h8c, 32'h01, 2'b00);
		bus(1, 8'h00, 32'h80, 2'b00);
		bus(0, 8'h80, 32'h00, 2'b10);
		bus(1, 8'h80, 32'h00, 2'b10);
		for (k = 0; k < 99 && level !== smp(1); k++)
			@(posedge sys_clk);
		for (k = 0; k < 48; k++)
		begin
			chk(34'(level), 34'(smp((k / 3 + 1) % 8)));
			@(posedge sys_clk);
		end
		bus(1, 8'h04, 32'h20, 2'b00);
		bus(1, 8'h00, 32'h81, 2'b00);
		bus(0, 8'h00, 32'h81, 2'b00);
		chk(34'(level), 34'(smp(0)));
		bus(1, 8'h00, 32'h80, 2'b00);
		for (k = 0; k < 99 && level === smp(0); k++)
			@(posedge sys_clk);
		chk(34'(level), 34'(smp(1)));
		bus(1, 8'h00, 32'h00, 2'b00);
		bus(0, 8'h80, 32'hc3, 2'b00);
		chk(34'(dac_drive), 34'h0);
		final_report();
	end
endmodule
